//--- design/wdt_consts.svh
// Purpose: Named offsets, bit positions and counts of the watchdog block
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Definitions only
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// APB byte offsets
`define WDT_OFF_CS        12'h000
`define WDT_OFF_KEY       12'h004
`define WDT_OFF_SEL       12'h008
`define WDT_OFF_IRQ       12'h00C

// Control/status bit positions
`define WDT_BIT_RESTART   0
`define WDT_BIT_RST_EN    1
`define WDT_BIT_CAUSE     2
`define WDT_BIT_TIMEOUT   3
`define WDT_BIT_PWRUP     6

// Interrupt enable bit positions
`define WDT_BIT_WDIE      0
`define WDT_BIT_GIE       1

// Timed access key bytes and open window length in clocks
`define WDT_KEY_FIRST     8'hAA
`define WDT_KEY_SECOND    8'h55
`define WDT_TA_WINDOW     4'h8

// Reset values
`define WDT_SEL_RESET     2'h0
`define WDT_PWRUP_RESET   1'b1

// Delay from time-out to system reset, in clocks
`define WDT_POST_CLKS     10'h200
`define WDT_POST_LAST     10'h1FF

`endif

//--- design/wdt_pkg.sv
// Purpose: Types shared by the watchdog modules
// Assumes: Nothing
// Notes:   Constants live in wdt_consts.svh
package wdt_pkg;
  typedef logic [1:0] wdt_sel_t;
  typedef enum logic [1:0] {WDT_TA_IDLE, WDT_TA_HALF, WDT_TA_OPEN} wdt_ta_e;
endpackage

//--- design/wdt_ctl_if.sv
// Purpose: Control and event signals between watchdog top and divider
// Assumes: Both ends on pclk
// Notes:   No clocking block
`timescale 1ns/1ps
interface wdt_ctl_if;
  import wdt_pkg::*;
  logic     restart;
  logic     run;
  wdt_sel_t sel;
  logic     timeout;
  logic     expire;
  modport top (output restart, output run, output sel,
               input timeout, input expire);
  modport div (input restart, input run, input sel,
               output timeout, output expire);
endinterface

//--- design/wdt_divider.sv
// Purpose: Free-running divider chain with time-out and post-delay counter
// Assumes: restart is a level or pulse on pclk
// Notes:   expire pulses 512 clocks after a time-out unless restarted
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_divider
  import wdt_pkg::*;
#(
  parameter int unsigned E0 = 17,
  parameter int unsigned E1 = 20,
  parameter int unsigned E2 = 23,
  parameter int unsigned E3 = 26
)(
  input wire logic pclk,
  input wire logic presetn,
  wdt_ctl_if.div   ctl
);
  localparam int unsigned W = E3;

  logic [W-1:0] cnt;
  logic [W-1:0] mask;
  logic [9:0]   post_cnt;
  logic         armed;
  logic         terminal;

  ////////////////////////////////////////////////////////////////////////////
  // Selected interval as a mask of low counter bits
  always_comb begin
    unique case (ctl.sel)
      2'h0:    mask = W'((64'h1 << E0) - 64'h1);
      2'h1:    mask = W'((64'h1 << E1) - 64'h1);
      2'h2:    mask = W'((64'h1 << E2) - 64'h1);
      2'h3:    mask = W'((64'h1 << E3) - 64'h1);
    endcase
  end

  assign terminal    = ctl.run && ((cnt & mask) == mask);
  assign ctl.timeout = terminal;
  assign ctl.expire  = armed && (post_cnt == `WDT_POST_LAST);

  // Divider chain, cleared by restart, counts while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (ctl.restart) begin
      cnt <= '0;
    end else if (ctl.run) begin
      cnt <= cnt + 1'b1;
    end
  end

  // Post time-out delay before a system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed    <= 1'b0;
      post_cnt <= '0;
    end else if (ctl.restart) begin
      armed    <= 1'b0;
      post_cnt <= '0;
    end else if (terminal && !armed) begin
      armed    <= 1'b1;
      post_cnt <= '0;
    end else if (armed) begin
      if (post_cnt == `WDT_POST_LAST) begin
        armed <= 1'b0;
      end
      post_cnt <= post_cnt + 10'h001;
    end
  end
endmodule

//--- design/wdt_timed_access.sv
// Purpose: Two-byte key sequence opening a short write window
// Assumes: key_wr and close are one-cycle strobes on pclk
// Notes:   A wrong byte drops the sequence back to idle
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_timed_access
  import wdt_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       close,
  output logic            open
);
  wdt_ta_e    state;
  logic [3:0] win;

  assign open = (state == WDT_TA_OPEN);

  // Key sequence and window timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= WDT_TA_IDLE;
      win   <= 4'h0;
    end else if (key_wr) begin
      if (key_data == `WDT_KEY_FIRST) begin
        state <= WDT_TA_HALF;
      end else if (state == WDT_TA_HALF && key_data == `WDT_KEY_SECOND) begin
        state <= WDT_TA_OPEN;
        win   <= `WDT_TA_WINDOW;
      end else begin
        state <= WDT_TA_IDLE;
      end
    end else begin
      unique case (state)
        WDT_TA_IDLE: state <= WDT_TA_IDLE;
        WDT_TA_HALF: state <= WDT_TA_HALF;
        WDT_TA_OPEN: begin
          if (close || win == 4'h1) begin
            state <= WDT_TA_IDLE;
          end
          win <= win - 4'h1;
        end
        default:     state <= WDT_TA_IDLE;
      endcase
    end
  end
endmodule

//--- design/wdt_top.sv
// Purpose: Watchdog timer monitor with APB register access
// Assumes: presetn is the power-on/power-fail reset; pclk 20 MHz
// Notes:   ext_reset_n is the chip external reset pin, synchronised here
//          Flag sets win over software writes in the same cycle
//          wdt_sys_reset is an output only and resets nothing in here
//
// Summary of operation
// - Free-running divider on the system clock sets the time-out interval.
// - Two-bit select: 2^17, 2^20, 2^23 or 2^26 clocks.
// - Time-out sets the time-out flag, control/status bit 3.
// - The flag sets even with the interrupt disabled, for polling.
// - Hardware never clears the time-out flag; software does.
// - Interrupt raised when flag, watchdog and global enables all set.
// - Interrupt and reset paths are enabled independently.
// - With reset enabled and no restart, reset follows 512 clocks later.
// - Watchdog reset lasts two machine cycles and sets the cause flag.
// - Cause flag cleared only by software write or power-fail reset.
// - With reset disabled the watchdog never touches the cause flag.
// - Bit 1 enables the watchdog reset; clear means no reset.
// - Writing restart bit 0 clears the divider; the bit self-clears.
// - Power-on or power-fail reset disables the watchdog.
// - External or watchdog reset restarts the count, not disabling it.
// - Power-up flag bit 6 set at power-up; cleared only by software.
// - Enable, flag and restart writes need key AAh then 55h first.
// - Time-out select resets to the shortest 2^17 interval.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned SEL0_EXP = 17,
  parameter int unsigned SEL1_EXP = 20,
  parameter int unsigned SEL2_EXP = 23,
  parameter int unsigned SEL3_EXP = 26,
  parameter int unsigned MC_CLKS  = 4
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_n,
  output logic             wdt_irq,
  output logic             wdt_sys_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  // Exponents must rise; the widest one sets the counter width
  generate
    if (!(SEL0_EXP > 0 && SEL0_EXP < SEL1_EXP && SEL1_EXP < SEL2_EXP &&
          SEL2_EXP < SEL3_EXP && SEL3_EXP <= 30)) begin : g_bad_exp
      $error("wdt_top: interval exponents must rise and stay below 31");
    end
    if (MC_CLKS < 1 || MC_CLKS > 7) begin : g_bad_mc
      $error("wdt_top: MC_CLKS must be 1 to 7");
    end
  endgenerate

  localparam logic [3:0] RST_LAST = 4'((2 * MC_CLKS) - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wdt_ctl_if ctl ();

  // Pin synchroniser
  logic        ext_meta;
  logic        ext_sync;

  // Bus decode and key window
  logic        bus_wr;
  logic        bus_setup;
  logic        addr_ok;
  logic        cs_wr;
  logic        key_wr;
  logic        sel_wr;
  logic        irq_wr;
  logic        ta_open;

  // Register bits
  logic        pwrup_flag;
  logic        timeout_flag;
  logic        cause_flag;
  logic        reset_enable;
  logic        restart_bit;
  logic        running;
  wdt_sel_t    timeout_sel;
  logic        wd_irq_en;
  logic        global_irq_en;

  // Reset pulse and read path
  logic        rst_start;
  logic [3:0]  rst_cnt;
  logic [7:0]  cs_value;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // External reset pin synchroniser
  // Both stages reset high, so power-up brings no false restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end else begin
      ext_meta <= ext_reset_n;
      ext_sync <= ext_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; the slave never waits
  assign pready    = 1'b1;
  assign bus_setup = psel && !penable;
  assign bus_wr    = psel && penable && pwrite;
  assign addr_ok   = (paddr == `WDT_OFF_CS)  || (paddr == `WDT_OFF_KEY) ||
                     (paddr == `WDT_OFF_SEL) || (paddr == `WDT_OFF_IRQ);
  assign pslverr   = psel && penable && !addr_ok;

  // One write strobe per register, in the access phase
  assign cs_wr     = bus_wr && (paddr == `WDT_OFF_CS);
  assign key_wr    = bus_wr && (paddr == `WDT_OFF_KEY);
  assign sel_wr    = bus_wr && (paddr == `WDT_OFF_SEL);
  assign irq_wr    = bus_wr && (paddr == `WDT_OFF_IRQ);

  // Key sequence unlocking the protected bits
  wdt_timed_access u_ta (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (key_wr),
    .key_data (pwdata[7:0]),
    .close    (cs_wr),
    .open     (ta_open)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-up flag: set by the power-on reset or by a control/status write of one to bit 6
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrup_flag <= `WDT_PWRUP_RESET;
    end else if (cs_wr) begin
      pwrup_flag <= pwdata[`WDT_BIT_PWRUP];
    end
  end

  // Reset enable, protected by the key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_enable <= 1'b0;
    end else if (cs_wr && ta_open) begin
      reset_enable <= pwdata[`WDT_BIT_RST_EN];
    end
  end

  // Time-out flag: hardware sets, software writes; the set wins
  // A clear meeting a time-out loses, so no time-out goes unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
    end else if (ctl.timeout) begin
      timeout_flag <= 1'b1;
    end else if (cs_wr && ta_open) begin
      timeout_flag <= pwdata[`WDT_BIT_TIMEOUT];
    end
  end

  // Reset-cause flag: set by a watchdog reset, write zero to clear
  // Writing one leaves it alone; only a zero clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_flag <= 1'b0;
    end else if (rst_start) begin
      cause_flag <= 1'b1;
    end else if (cs_wr) begin
      cause_flag <= cause_flag & pwdata[`WDT_BIT_CAUSE];
    end
  end

  // Restart bit: one-cycle pulse, self-clearing
  // Reads back as one only in the cycle after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_bit <= 1'b0;
    end else begin
      restart_bit <= cs_wr && ta_open && pwdata[`WDT_BIT_RESTART];
    end
  end

  // Watchdog runs once started; only the power-on reset stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (restart_bit) begin
      running <= 1'b1;
    end
  end

  // Interval select
  // A new select applies to the running count at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_sel <= `WDT_SEL_RESET;
    end else if (sel_wr) begin
      timeout_sel <= pwdata[1:0];
    end
  end

  // Interrupt enables
  // The global enable lives here as a local bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_irq_en     <= 1'b0;
      global_irq_en <= 1'b0;
    end else if (irq_wr) begin
      wd_irq_en     <= pwdata[`WDT_BIT_WDIE];
      global_irq_en <= pwdata[`WDT_BIT_GIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider control; external or watchdog reset restarts the count
  assign ctl.restart = restart_bit || !ext_sync || rst_start;
  assign ctl.run     = running;
  assign ctl.sel     = timeout_sel;

  // Divider chain and post time-out delay
  wdt_divider #(
    .E0 (SEL0_EXP),
    .E1 (SEL1_EXP),
    .E2 (SEL2_EXP),
    .E3 (SEL3_EXP)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl.div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System reset pulse of two machine cycles
  assign rst_start = ctl.expire && reset_enable && !wdt_sys_reset;

  // Counts the pulse down; a new expiry cannot stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_sys_reset <= 1'b0;
      rst_cnt       <= 4'h0;
    end else if (rst_start) begin
      wdt_sys_reset <= 1'b1;
      rst_cnt       <= RST_LAST;
    end else if (wdt_sys_reset) begin
      if (rst_cnt == 4'h0) begin
        wdt_sys_reset <= 1'b0;
      end
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  // Interrupt request, independent of the reset path
  // Follows the flag, so clearing the flag drops the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq <= 1'b0;
    end else begin
      wdt_irq <= timeout_flag && wd_irq_en && global_irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase
  always_comb begin
    cs_value = 8'h00;
    cs_value[`WDT_BIT_PWRUP]   = pwrup_flag;
    cs_value[`WDT_BIT_TIMEOUT] = timeout_flag;
    cs_value[`WDT_BIT_CAUSE]   = cause_flag;
    cs_value[`WDT_BIT_RST_EN]  = reset_enable;
    cs_value[`WDT_BIT_RESTART] = restart_bit;
    // Unmapped words and the key register read as zero
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      `WDT_OFF_CS:  next_rdata[7:0] = cs_value;
      `WDT_OFF_SEL: next_rdata[1:0] = timeout_sel;
      `WDT_OFF_IRQ: begin
        next_rdata[`WDT_BIT_WDIE] = wd_irq_en;
        next_rdata[`WDT_BIT_GIE]  = global_irq_en;
      end
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  // Held from the setup edge so the word stands all access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (bus_setup) begin
      prdata <= next_rdata;
    end
  end
endmodule

//--- test/wdt_top_sva.sv
// Purpose: Port-level assertions for the watchdog block
// Assumes: Bound into wdt_top; shadows follow completed APB writes
// Notes:   Flags are internal, so only relations seen at ports are held
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top_sva
  import wdt_pkg::*;
#(
  parameter int unsigned MC_CLKS = 4
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_reset_n,
  input wire logic        wdt_irq,
  input wire logic        wdt_sys_reset
);
  logic [1:0] sel_s;
  logic [1:0] irq_s;
  logic       pwr_s;
  logic [4:0] hc;
  logic       acc;
  logic       rd_ph;
  logic       mapped;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer decode
  assign acc = psel & penable & pready;
  assign rd_ph = psel & penable & !pwrite;
  assign mapped = paddr inside {`WDT_OFF_CS, `WDT_OFF_KEY, `WDT_OFF_SEL,
                                `WDT_OFF_IRQ};

  // Shadow of the freely writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s <= `WDT_SEL_RESET;
      irq_s <= 2'h0;
      pwr_s <= `WDT_PWRUP_RESET;
    end else if (acc && pwrite) begin
      if (paddr == `WDT_OFF_SEL) sel_s <= pwdata[1:0];
      if (paddr == `WDT_OFF_IRQ) irq_s <= pwdata[1:0];
      if (paddr == `WDT_OFF_CS) pwr_s <= pwdata[`WDT_BIT_PWRUP];
    end
  end

  // Cycles the reset output has been high so far
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc <= 5'h0;
    end else begin
      hc <= wdt_sys_reset ? hc + 5'h1 : 5'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sel_back: assert property (rd_ph && paddr == `WDT_OFF_SEL
    |-> prdata == {30'h0, sel_s}) else $error("select readback wrong");
  a_irq_back: assert property (rd_ph && paddr == `WDT_OFF_IRQ
    |-> prdata == {30'h0, irq_s}) else $error("irq enable readback wrong");
  a_pwrup_back: assert property (rd_ph && paddr == `WDT_OFF_CS
    |-> prdata[6] == pwr_s) else $error("power-up flag wrong");
  a_rsvd_zero: assert property (rd_ph && paddr == `WDT_OFF_CS
    |-> prdata[31:7] == 25'h0 && prdata[5:4] == 2'h0)
    else $error("reserved bits not zero");
  a_irq_gate: assert property (wdt_irq |-> $past(irq_s) == 2'h3)
    else $error("irq without both enables");
  a_pulse_len: assert property ($fell(wdt_sys_reset)
    |-> hc == 5'(2 * MC_CLKS)) else $error("reset pulse length wrong");
  a_pulse_gap: assert property ($fell(wdt_sys_reset)
    |-> !wdt_sys_reset [*8]) else $error("reset pulses too close");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_unmap_zero: assert property (rd_ph && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind wdt_top wdt_top_sva #(.MC_CLKS(MC_CLKS)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
  .wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset));

//--- test/tb.sv
// Purpose: Self-checking bench for the watchdog block over APB
// Assumes: Short select exponents 4..7 stand in for 17..26
// Notes:   Flag timing is checked within a polling tolerance
`timescale 1ns/1ps
`include "wdt_consts.svh"
module tb;
  import wdt_pkg::*;
  localparam int EX [4] = '{4, 5, 6, 7};
  logic        pclk, presetn, psel, penable, pwrite, ext_reset_n;
  logic        pready, pslverr, wdt_irq, wdt_sys_reset, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int          fail_count, n_compared, cyc, dt, n_rst, i;
  int          m_pwr, m_cause, m_ren, m_sel, m_irq;
  bit          kopen;

  wdt_top #(.SEL0_EXP(4), .SEL1_EXP(5), .SEL2_EXP(6), .SEL3_EXP(7),
    .MC_CLKS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_n(ext_reset_n), .wdt_irq(wdt_irq),
    .wdt_sys_reset(wdt_sys_reset));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle count and reset pulse count
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc++;
  always @(posedge wdt_sys_reset) n_rst++;

  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] csx();
    return 32'((m_pwr << 6) | (m_cause << 2) | (m_ren << 1));
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == `WDT_OFF_CS) begin
      m_pwr = d[6];
      m_cause = m_cause & d[2];
      if (kopen) m_ren = d[1];
    end
    if (a == `WDT_OFF_SEL) m_sel = d[1:0];
    if (a == `WDT_OFF_IRQ) m_irq = d[1:0];
    kopen = 0;
  endtask

  task automatic prot(input logic [31:0] d);
    wr(`WDT_OFF_KEY, 32'h0000_00AA);
    wr(`WDT_OFF_KEY, 32'h0000_0055);
    kopen = 1;
    wr(`WDT_OFF_CS, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv & m, x);
  endtask

  // Polls until the time-out flag reads set
  task automatic tmo();
    int t0;
    t0 = cyc;
    rv = 32'h0000_0000;
    while (rv[3] !== 1'b1 && cyc - t0 < 900) apb(1'b0, `WDT_OFF_CS, 0);
    dt = cyc - t0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m_cause, m_ren, m_sel, m_irq} = '0;
    m_pwr = 1;
    ext_reset_n = 1'b1;
    presetn = 1'b0;
    void'($urandom(32'hf7ba));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped place, unprotected writes
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFFF);
    rd(`WDT_OFF_SEL, 32'h0, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, 0);
    chk({rv[30:0], ev}, 32'h1);
    for (i = 0; i < 8; i++) begin
      wr(`WDT_OFF_CS, $urandom);
      rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFFF);
      wr(`WDT_OFF_SEL, $urandom);
      rd(`WDT_OFF_SEL, 32'(m_sel), 32'hFFFF_FFFF);
      wr(`WDT_OFF_IRQ, $urandom);
      rd(`WDT_OFF_IRQ, 32'(m_irq), 32'hFFFF_FFFF);
    end
    // Each select code, flag polled with interrupts off
    wr(`WDT_OFF_IRQ, 0);
    for (i = 0; i < 4; i++) begin
      wr(`WDT_OFF_SEL, i);
      // Second kick lands before any time-out, so the flag clears
      repeat (2) prot(32'h0000_0001);
      tmo();
      chk(dt >= 2**EX[i] - 3 && dt <= 2**EX[i] + 6, 1);
      chk(wdt_irq, 0);
    end
    repeat (600) @(posedge pclk);
    rd(`WDT_OFF_CS, csx() | 32'h8, 32'hFFFF_FFFE);
    chk(n_rst, 0);
    // Interrupt needs both enables
    for (i = 1; i < 4; i++) begin
      wr(`WDT_OFF_IRQ, i);
      repeat (2) @(posedge pclk);
      chk(wdt_irq, i == 3);
    end
    wr(`WDT_OFF_IRQ, 0);
    // Reset 512 clocks after time-out
    wr(`WDT_OFF_SEL, 0);
    prot(32'h0000_0003);
    dt = cyc;
    while (wdt_sys_reset !== 1'b1 && cyc - dt < 2000) @(posedge pclk);
    chk(cyc - dt >= 526 && cyc - dt <= 534, 1);
    repeat (12) @(posedge pclk);
    m_cause = 1;
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFF6);
    repeat (20) @(posedge pclk);
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFF6);
    // Kicks in time hold the reset off
    for (i = 0; i < 70; i++) prot(32'h0000_0003);
    chk(n_rst, 1);
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFF6);
    // External reset restarts the count
    prot(32'h0000_0001);
    repeat (8) @(posedge pclk);
    ext_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    ext_reset_n <= 1'b1;
    tmo();
    chk(dt >= 12 && dt <= 26, 1);
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFF6);
    // Power-on reset mid-run stops the watchdog
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {m_cause, m_ren, m_sel, m_irq} = '0;
    m_pwr = 1;
    repeat (100) @(posedge pclk);
    rd(`WDT_OFF_CS, csx(), 32'hFFFF_FFFF);
    tally_and_finish();
  end
endmodule
